// File: verilog/nvc_pkg.sv
// Constants, register map and types for the nonvolatile access controller
package nvc_pkg;

  // Register offsets on the special function register space
  localparam logic [8:0] ADDR_DATA_LOW     = 9'h10c;
  localparam logic [8:0] ADDR_ADDRESS_LOW  = 9'h10d;
  localparam logic [8:0] ADDR_ADDRESS_HIGH = 9'h10f;
  localparam logic [8:0] ADDR_CONTROL      = 9'h11b;
  localparam logic [8:0] ADDR_UNLOCK       = 9'h11c;
  localparam logic [8:0] ADDR_DATA_HIGH    = 9'h18e;

  // Control register bit positions
  localparam int CTL_SPACE  = 7;
  localparam int CTL_TIME_H = 5;
  localparam int CTL_TIME_L = 4;
  localparam int CTL_FAULT  = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WSTART = 1;
  localparam int CTL_RSTART = 0;

  // Memory geometry
  localparam int EE_DEPTH   = 128;
  localparam int EE_AW      = 7;
  localparam int EE_DW      = 8;
  localparam int PROG_AW    = 13;
  localparam int PROG_DW    = 16;
  localparam int ADDR_HI_W  = 5;

  // Unlock keys and reset values
  localparam logic [7:0] UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2  = 8'haa;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [1:0] TIME_RESET   = 2'h0;

  // Write time limits in ns and clock period in ns; every limit divides into whole cycles
  localparam int CLK_NS       = 10;
  localparam int T_LIM0_NS    = 1250000;
  localparam int T_LIM1_NS    = 2500000;
  localparam int T_LIM2_NS    = 5000000;
  localparam int T_LIM3_NS    = 10000000;
  localparam int T_LIM0_CYC   = T_LIM0_NS / CLK_NS;
  localparam int T_LIM1_CYC   = T_LIM1_NS / CLK_NS;
  localparam int T_LIM2_CYC   = T_LIM2_NS / CLK_NS;
  localparam int T_LIM3_CYC   = T_LIM3_NS / CLK_NS;
  localparam int TIMER_W      = 20;

  // Access sequencer, Gray coded along idle, read wait, read latch, write
  typedef enum logic [1:0] {
    NVC_IDLE     = 2'b00,
    NVC_RD_WAIT  = 2'b01,
    NVC_RD_LATCH = 2'b11,
    NVC_WRITE    = 2'b10
  } nvc_state_t;

  // Unlock sequence progress
  typedef enum logic [1:0] {
    NVC_UL_NONE  = 2'b00,
    NVC_UL_FIRST = 2'b01,
    NVC_UL_ARMED = 2'b11
  } nvc_unlock_t;

endpackage

// File: verilog/nvc_write_timer.sv
// Write duration limit counter with selectable maximum time
`timescale 1ns/1ps
`default_nettype none
module nvc_write_timer #(
  parameter int CW  = nvc_pkg::TIMER_W,
  parameter int LIM0 = nvc_pkg::T_LIM0_CYC,
  parameter int LIM1 = nvc_pkg::T_LIM1_CYC,
  parameter int LIM2 = nvc_pkg::T_LIM2_CYC,
  parameter int LIM3 = nvc_pkg::T_LIM3_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            expired
);

  logic [CW-1:0] count_q;
  logic [CW-1:0] limit;

  function automatic logic [CW-1:0] limit_of(input logic [1:0] s);
    unique case (s)
      2'h0: limit_of = CW'(LIM0);
      2'h1: limit_of = CW'(LIM1);
      2'h2: limit_of = CW'(LIM2);
      2'h3: limit_of = CW'(LIM3);
    endcase
  endfunction

  assign limit = limit_of(sel);

  // Counter restarts whenever the write is not running
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clk_en) begin
      if (!run) begin
        count_q <= '0;
      end else if (!expired) begin
        count_q <= count_q + CW'(1);
      end
    end
  end

  assign expired = run && (count_q >= limit - CW'(1));

endmodule
`default_nettype wire

// File: verilog/nvc_ee_array.sv
// Byte-wide data EEPROM storage held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module nvc_ee_array #(
  parameter int AW = nvc_pkg::EE_AW,
  parameter int DW = nvc_pkg::EE_DW
) (
  input  wire logic          sys_clk,
  input  wire logic          clk_en,
  input  wire logic          erase,
  input  wire logic          prog,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] cell_q [2**AW];

  // Erase leaves the cell at the blank value before programming
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (prog) begin
        cell_q[addr] <= wdata;
      end else if (erase) begin
        cell_q[addr] <= DW'(nvc_pkg::ERASED_BYTE);
      end
    end
  end

  assign rdata = cell_q[addr];

endmodule
`default_nettype wire

// File: verilog/nvc_ctrl.sv
// Nonvolatile memory access controller behind the CPU special registers
`timescale 1ns/1ps
`default_nettype none

module nvc_ctrl #(
  parameter int LIM0 = nvc_pkg::T_LIM0_CYC,
  parameter int LIM1 = nvc_pkg::T_LIM1_CYC,
  parameter int LIM2 = nvc_pkg::T_LIM2_CYC,
  parameter int LIM3 = nvc_pkg::T_LIM3_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire logic                         lv_reset,
  input  wire logic                         wdt_reset,
  input  wire logic [8:0]                   sfr_addr,
  input  wire logic                         sfr_wr,
  input  wire logic                         sfr_rd,
  input  wire logic [7:0]                   sfr_wdata,
  output logic      [7:0]                   sfr_rdata,
  output logic      [nvc_pkg::PROG_AW-1:0]  prog_mem_addr,
  input  wire logic [nvc_pkg::PROG_DW-1:0]  prog_mem_data,
  input  wire logic                         verify_ok,
  output logic                              write_done_flag,
  input  wire logic                         write_done_clr,
  output logic                              cpu_stall,
  input  wire logic                         code_protect,
  output logic                              programmer_access_en
);

  nvc_pkg::nvc_state_t  state_q;
  nvc_pkg::nvc_unlock_t unlock_q;

  logic [7:0]                    data_low_q;
  logic [7:0]                    data_high_q;
  logic [7:0]                    addr_low_q;
  logic [nvc_pkg::ADDR_HI_W-1:0] addr_high_q;
  logic                          space_q;
  logic [1:0]                    time_q;
  logic                          fault_q;
  logic                          permit_q;
  logic                          done_q;

  logic                          soft_rst;
  logic                          wr_dlow;
  logic                          wr_alow;
  logic                          wr_ahigh;
  logic                          wr_ctl;
  logic                          wr_unlock;
  logic                          wr_dhigh;
  logic                          rd_go;
  logic                          wr_go;
  logic                          expired;
  logic                          wr_end;
  logic                          ee_erase;
  logic                          ee_prog;
  logic [nvc_pkg::EE_DW-1:0]     ee_rdata;
  logic [7:0]                    ctl_view;
  logic [7:0]                    rd_mux;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction

  assign soft_rst  = lv_reset | wdt_reset;
  assign wr_dlow   = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_DATA_LOW);
  assign wr_alow   = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_ADDRESS_LOW);
  assign wr_ahigh  = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_ADDRESS_HIGH);
  assign wr_ctl    = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_CONTROL);
  assign wr_unlock = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_UNLOCK);
  assign wr_dhigh  = sfr_wr && hit(sfr_addr, nvc_pkg::ADDR_DATA_HIGH);

  assign rd_go = wr_ctl && sfr_wdata[nvc_pkg::CTL_RSTART]
                 && (state_q == nvc_pkg::NVC_IDLE);

  assign wr_go = wr_ctl && sfr_wdata[nvc_pkg::CTL_WSTART]
                 && (state_q == nvc_pkg::NVC_IDLE)
                 && (unlock_q == nvc_pkg::NVC_UL_ARMED)
                 && permit_q
                 && !sfr_wdata[nvc_pkg::CTL_SPACE]
                 && !rd_go;

  assign wr_end = (state_q == nvc_pkg::NVC_WRITE) && (verify_ok || expired);

  // erase at start, program at end
  assign ee_erase = wr_go;
  assign ee_prog  = wr_end && !soft_rst;

  // CPU path never gated, only the programmer
  assign programmer_access_en = !code_protect;

  assign cpu_stall = (state_q != nvc_pkg::NVC_IDLE);

  assign prog_mem_addr = {addr_high_q, addr_low_q};

  assign write_done_flag = done_q;

  nvc_write_timer #(
    .CW   (nvc_pkg::TIMER_W),
    .LIM0 (LIM0),
    .LIM1 (LIM1),
    .LIM2 (LIM2),
    .LIM3 (LIM3)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (state_q == nvc_pkg::NVC_WRITE),
    .sel     (time_q),
    .expired (expired)
  );

  nvc_ee_array #(
    .AW (nvc_pkg::EE_AW),
    .DW (nvc_pkg::EE_DW)
  ) u_array (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .erase   (ee_erase),
    .prog    (ee_prog),
    .addr    (addr_low_q[nvc_pkg::EE_AW-1:0]),
    .wdata   (data_low_q),
    .rdata   (ee_rdata)
  );

  // Access sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= nvc_pkg::NVC_IDLE;
    end else if (clk_en) begin
      if (soft_rst) begin
        state_q <= nvc_pkg::NVC_IDLE;
      end else begin
        unique case (state_q)
          nvc_pkg::NVC_IDLE: begin
            if (rd_go) begin
              state_q <= nvc_pkg::NVC_RD_WAIT;
            end else if (wr_go) begin
              state_q <= nvc_pkg::NVC_WRITE;
            end
          end
          nvc_pkg::NVC_RD_WAIT: begin
            state_q <= nvc_pkg::NVC_RD_LATCH;
          end
          nvc_pkg::NVC_RD_LATCH: begin
            state_q <= nvc_pkg::NVC_IDLE;
          end
          nvc_pkg::NVC_WRITE: begin
            if (wr_end) begin
              state_q <= nvc_pkg::NVC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Unlock sequence tracker; any other register write breaks it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= nvc_pkg::NVC_UL_NONE;
    end else if (clk_en) begin
      if (soft_rst) begin
        unlock_q <= nvc_pkg::NVC_UL_NONE;
      end else if (wr_unlock) begin
        if (sfr_wdata == nvc_pkg::UNLOCK_KEY1) begin
          unlock_q <= nvc_pkg::NVC_UL_FIRST;
        end else if (sfr_wdata == nvc_pkg::UNLOCK_KEY2
                     && unlock_q == nvc_pkg::NVC_UL_FIRST) begin
          unlock_q <= nvc_pkg::NVC_UL_ARMED;
        end else begin
          unlock_q <= nvc_pkg::NVC_UL_NONE;
        end
      end else if (sfr_wr) begin
        unlock_q <= nvc_pkg::NVC_UL_NONE;
      end
    end
  end

  // Address registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_low_q  <= nvc_pkg::BYTE_ZERO;
      addr_high_q <= '0;
    end else if (clk_en) begin
      if (soft_rst) begin
        addr_low_q  <= nvc_pkg::BYTE_ZERO;
        addr_high_q <= '0;
      end else begin
        if (wr_alow) begin
          addr_low_q <= sfr_wdata;
        end
        if (wr_ahigh) begin
          addr_high_q <= sfr_wdata[nvc_pkg::ADDR_HI_W-1:0];
        end
      end
    end
  end

  // Space select and time limit field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      space_q <= 1'b0;
      time_q  <= nvc_pkg::TIME_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        space_q <= 1'b0;
        time_q  <= nvc_pkg::TIME_RESET;
      end else if (wr_ctl) begin
        space_q <= sfr_wdata[nvc_pkg::CTL_SPACE];
        time_q  <= sfr_wdata[nvc_pkg::CTL_TIME_H:nvc_pkg::CTL_TIME_L];
      end
    end
  end

  // Permit survives watchdog and low-voltage resets on purpose
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      permit_q <= 1'b0;
    end else if (clk_en && !soft_rst && wr_ctl) begin
      permit_q <= sfr_wdata[nvc_pkg::CTL_PERMIT];
    end
  end

  // Fault flag; hardware set beats a software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst && state_q == nvc_pkg::NVC_WRITE) begin
        fault_q <= 1'b1;
      end else if (!soft_rst && wr_end && !verify_ok) begin
        fault_q <= 1'b1;
      end else if (!soft_rst && wr_ctl) begin
        fault_q <= sfr_wdata[nvc_pkg::CTL_FAULT];
      end
    end
  end

  // Write done flag; set wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_end && !soft_rst) begin
        done_q <= 1'b1;
      end else if (write_done_clr) begin
        done_q <= 1'b0;
      end
    end
  end

  // Data registers hold their value across soft resets
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_low_q  <= nvc_pkg::BYTE_ZERO;
      data_high_q <= nvc_pkg::BYTE_ZERO;
    end else if (clk_en) begin
      if (state_q == nvc_pkg::NVC_RD_LATCH) begin
        if (space_q) begin
          data_low_q  <= prog_mem_data[7:0];
          data_high_q <= prog_mem_data[15:8];
        end else begin
          data_low_q <= ee_rdata;
        end
      end else begin
        if (wr_dlow) begin
          data_low_q <= sfr_wdata;
        end
        if (wr_dhigh) begin
          data_high_q <= sfr_wdata;
        end
      end
    end
  end

  assign ctl_view = {space_q, 1'b0, time_q, fault_q, permit_q,
                     state_q == nvc_pkg::NVC_WRITE,
                     state_q == nvc_pkg::NVC_RD_WAIT
                     || state_q == nvc_pkg::NVC_RD_LATCH};

  always_comb begin
    rd_mux = nvc_pkg::BYTE_ZERO;
    unique case (sfr_addr)
      nvc_pkg::ADDR_DATA_LOW:     rd_mux = data_low_q;
      nvc_pkg::ADDR_ADDRESS_LOW:  rd_mux = addr_low_q;
      nvc_pkg::ADDR_ADDRESS_HIGH: rd_mux = {3'h0, addr_high_q};
      nvc_pkg::ADDR_CONTROL:      rd_mux = ctl_view;
      nvc_pkg::ADDR_DATA_HIGH:    rd_mux = data_high_q;
      nvc_pkg::ADDR_UNLOCK:       rd_mux = nvc_pkg::BYTE_ZERO;
      default:                    rd_mux = nvc_pkg::BYTE_ZERO;
    endcase
  end

  // Read data is registered, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= nvc_pkg::BYTE_ZERO;
    end else if (clk_en && sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// File: dv/nvc_far_model.sv
// Far-side model: program memory words and write self-verification
`timescale 1ns/1ps
`default_nettype none
module nvc_far_model (
  input  wire logic        sys_clk,
  input  wire logic        cpu_stall,
  input  wire logic [12:0] prog_mem_addr,
  input  wire logic [7:0]  verify_delay,
  output logic      [15:0] prog_mem_data,
  output logic             verify_ok
);
  logic [7:0] stall_cnt_q;

  // read-only words
  // No write path: each word is a fixed pattern of its own address
  assign prog_mem_data = {3'h5, prog_mem_addr};

  always_ff @(posedge sys_clk) begin
    stall_cnt_q <= cpu_stall ? stall_cnt_q + 8'h01 : 8'h00;
  end

  // verify after delay
  // Delay ff never verifies, so only the time limit or a soft reset can end the write
  assign verify_ok = cpu_stall && verify_delay != 8'hff
                     && stall_cnt_q == verify_delay;
endmodule
`default_nettype wire

// File: dv/nvc_ctrl_checker.sv
// Port-level assertions for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_checker #(
  parameter int LIM3 = nvc_pkg::T_LIM3_CYC
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        lv_reset,
  input wire logic        wdt_reset,
  input wire logic [8:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [12:0] prog_mem_addr,
  input wire logic        verify_ok,
  input wire logic        write_done_flag,
  input wire logic        write_done_clr,
  input wire logic        cpu_stall,
  input wire logic        code_protect,
  input wire logic        programmer_access_en
);
  logic        quiet;
  logic        ctl_wr;
  logic [19:0] stall_cnt_q;

  assign quiet  = clk_en && !cpu_stall && !lv_reset && !wdt_reset;
  assign ctl_wr = sfr_wr && quiet && sfr_addr == nvc_pkg::ADDR_CONTROL;

  // Stall length counter; a hung write shows up as a runaway count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_q <= 20'h00000;
    end else begin
      stall_cnt_q <= cpu_stall ? stall_cnt_q + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  prot_lockout_a: assert property (
    programmer_access_en == !code_protect)
    else $error("programmer access ignores protection");
  addr_route_a: assert property (
    sfr_wr && quiet && sfr_addr == nvc_pkg::ADDR_ADDRESS_LOW
    |=> prog_mem_addr[7:0] == $past(sfr_wdata))
    else $error("low address not routed");
  read_stall_a: assert property (
    ctl_wr && sfr_wdata[nvc_pkg::CTL_RSTART]
    && !sfr_wdata[nvc_pkg::CTL_WSTART]
    |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("read stall not two cycles");
  unlock_zero_a: assert property (
    sfr_rd && clk_en && sfr_addr == nvc_pkg::ADDR_UNLOCK
    |=> sfr_rdata == 8'h00)
    else $error("unlock port read not zero");
  high_bits_a: assert property (
    sfr_rd && clk_en && sfr_addr == nvc_pkg::ADDR_ADDRESS_HIGH
    |=> sfr_rdata[7:5] == 3'h0)
    else $error("high address top bits not zero");
  space_refuse_a: assert property (
    ctl_wr && sfr_wdata[nvc_pkg::CTL_WSTART]
    && sfr_wdata[nvc_pkg::CTL_SPACE] && !sfr_wdata[nvc_pkg::CTL_RSTART]
    |=> !cpu_stall)
    else $error("write started in program space");
  done_hold_a: assert property (
    write_done_flag && !write_done_clr |=> write_done_flag)
    else $error("done flag dropped without clear");
  done_cause_a: assert property (
    $rose(write_done_flag) |-> $fell(cpu_stall))
    else $error("done flag without write end");
  verify_end_a: assert property (
    cpu_stall && $past(cpu_stall, 2) && verify_ok && clk_en
    |=> !cpu_stall)
    else $error("write kept running after verify");
  write_bound_a: assert property (
    stall_cnt_q <= LIM3 + 4)
    else $error("write exceeded longest time limit");
endmodule
`default_nettype wire

// File: dv/nvc_ctrl_tb.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_tb;
  logic        sys_clk;
  logic        rst_n;
  logic        clk_en;
  logic        lv_reset;
  logic        wdt_reset;
  logic [8:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [12:0] prog_mem_addr;
  logic [15:0] prog_mem_data;
  logic        verify_ok;
  logic        write_done_flag;
  logic        write_done_clr;
  logic        cpu_stall;
  logic        code_protect;
  logic        programmer_access_en;
  logic [7:0]  verify_delay;
  logic [7:0]  rv;
  logic [12:0] a13;
  int          err_count;
  int          checked;
  int          n;

  // Short limits keep timeout runs brief
  nvc_ctrl #(.LIM0(8), .LIM1(16), .LIM2(32), .LIM3(64)) nvc_ctrl_inst (
    .sys_clk, .rst_n, .clk_en, .lv_reset, .wdt_reset, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .prog_mem_addr,
    .prog_mem_data, .verify_ok, .write_done_flag, .write_done_clr,
    .cpu_stall, .code_protect, .programmer_access_en);
  nvc_far_model nvc_far_model_inst (
    .sys_clk, .cpu_stall, .prog_mem_addr, .verify_delay,
    .prog_mem_data, .verify_ok);

  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
    #1;
    rv = sfr_rdata;
  endtask

  // Counts stall cycles after the starting write; bounded wait
  task automatic wait_idle();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 200) begin
        err_count++;
        complete_run();
      end
    end while (cpu_stall !== 1'b0);
  endtask

  task automatic ee_write(input logic [7:0] a, input logic [7:0] d,
                          input logic [7:0] t);
    wr(nvc_pkg::ADDR_ADDRESS_LOW, a);
    wr(nvc_pkg::ADDR_DATA_LOW, d);
    wr(nvc_pkg::ADDR_CONTROL, t | 8'h04);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_UNLOCK, 8'haa);
    wr(nvc_pkg::ADDR_CONTROL, t | 8'h06);
  endtask

  // Also clears the fault bit, since the control write stores it
  task automatic ee_read(input logic [7:0] a);
    wr(nvc_pkg::ADDR_ADDRESS_LOW, a);
    wr(nvc_pkg::ADDR_CONTROL, 8'h05);
    wait_idle();
    rd(nvc_pkg::ADDR_DATA_LOW);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    lv_reset = 1'b0;
    wdt_reset = 1'b0;
    sfr_addr = 9'h000;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    write_done_clr = 1'b0;
    code_protect = 1'b0;
    verify_delay = 8'hff;
    err_count = 0;
    checked = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(nvc_pkg::ADDR_CONTROL);
    chk(rv, 8'h00);
    chk(8'(write_done_flag), 8'h00);
    wr(nvc_pkg::ADDR_ADDRESS_HIGH, 8'hff);
    rd(nvc_pkg::ADDR_ADDRESS_HIGH);
    chk(rv, 8'h1f);
    // Clock enable low must freeze the register file
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(nvc_pkg::ADDR_ADDRESS_HIGH, 8'h03);
    clk_en <= 1'b1;
    rd(nvc_pkg::ADDR_ADDRESS_HIGH);
    chk(rv, 8'h1f);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    rd(nvc_pkg::ADDR_UNLOCK);
    chk(rv, 8'h00);
    rd(9'h100);
    chk(rv, 8'h00);
    chk(8'(programmer_access_en), 8'h01);
    for (int i = 0; i < 2; i++) begin
      a13 = (i == 0) ? 13'h0a5c : 13'h1fff;
      wr(nvc_pkg::ADDR_ADDRESS_HIGH, {3'h0, a13[12:8]});
      wr(nvc_pkg::ADDR_ADDRESS_LOW, a13[7:0]);
      wr(nvc_pkg::ADDR_CONTROL, 8'h81);
      wait_idle();
      chk(8'(n), 8'd2);
      rd(nvc_pkg::ADDR_DATA_LOW);
      chk(rv, a13[7:0]);
      rd(nvc_pkg::ADDR_DATA_HIGH);
      chk(rv, {3'h5, a13[12:8]});
      rd(nvc_pkg::ADDR_CONTROL);
      chk(rv, 8'h80);
    end
    ee_write(8'h05, 8'h3c, 8'h80);
    wait_idle();
    chk(8'(n), 8'd1);
    rd(nvc_pkg::ADDR_DATA_LOW);
    chk(rv, 8'h3c);
    wr(nvc_pkg::ADDR_CONTROL, 8'h00);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_UNLOCK, 8'haa);
    wr(nvc_pkg::ADDR_CONTROL, 8'h02);
    wait_idle();
    chk(8'(n), 8'd1);
    wr(nvc_pkg::ADDR_CONTROL, 8'h04);
    wr(nvc_pkg::ADDR_UNLOCK, 8'haa);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_CONTROL, 8'h06);
    wait_idle();
    chk(8'(n), 8'd1);
    for (int k = 0; k < 4; k++) begin
      ee_write(8'(16 + k), 8'(64 + k), 8'(k * 16));
      wait_idle();
      chk(8'(n >= (8 << k) && n <= (8 << k) + 2), 8'h01);
      rd(nvc_pkg::ADDR_CONTROL);
      chk(rv, 8'(k * 16 + 12));
      chk(8'(write_done_flag), 8'h01);
      @(posedge sys_clk);
      write_done_clr <= 1'b1;
      @(posedge sys_clk);
      write_done_clr <= 1'b0;
      #1;
      chk(8'(write_done_flag), 8'h00);
      ee_read(8'(16 + k));
      chk(rv, 8'(64 + k));
    end
    @(posedge sys_clk);
    code_protect <= 1'b1;
    verify_delay <= 8'd4;
    ee_write(8'h7f, 8'ha5, 8'h30);
    wait_idle();
    chk(8'(n), 8'd5);
    chk(8'(programmer_access_en), 8'h00);
    rd(nvc_pkg::ADDR_CONTROL);
    chk(rv, 8'h34);
    ee_read(8'h7f);
    chk(rv, 8'ha5);
    chk(8'(write_done_flag), 8'h01);
    // Flag from the verified write must go before the abort checks
    @(posedge sys_clk);
    verify_delay <= 8'hff;
    write_done_clr <= 1'b1;
    @(posedge sys_clk);
    write_done_clr <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      ee_write(8'h20, 8'h5a, 8'h30);
      repeat (3) @(posedge sys_clk);
      lv_reset <= (r == 0);
      wdt_reset <= (r == 1);
      @(posedge sys_clk);
      lv_reset <= 1'b0;
      wdt_reset <= 1'b0;
      #1;
      chk(8'(cpu_stall | write_done_flag), 8'h00);
      rd(nvc_pkg::ADDR_CONTROL);
      chk(rv, 8'h0c);
      ee_read(8'h20);
      chk(rv, 8'hff);
    end
    complete_run();
  end
endmodule

bind nvc_ctrl nvc_ctrl_checker #(.LIM3(LIM3)) nvc_ctrl_checker_inst (
  .sys_clk, .rst_n, .clk_en, .lv_reset, .wdt_reset, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .prog_mem_addr, .verify_ok,
  .write_done_flag, .write_done_clr, .cpu_stall, .code_protect,
  .programmer_access_en);
`default_nettype wire
